// *** src/opcode_decoder_pkg.sv ***
// Package with opcode decoder types, field positions and cycle counts
// Functional notes
// (RULE1) Three-bit register field selects B..L, memory, A
// (RULE2) Dual-count ops: short if condition fails
// (RULE3) Bits 5:4 select BC, DE, HL, SP
// (RULE4) 00pp d011 steps pair; six cycles
// (RULE5) 00pp1001 adds pair to HL; ten cycles
// (RULE6) 10000/10001 sss add register; four cycles
// (RULE7) Add memory operand forms take seven cycles
// (RULE8) Add immediate forms take seven cycles
// (RULE9) 10010/10011 sss subtract register; four cycles
// (RULE10) Subtract memory operand forms take seven cycles
// (RULE11) Subtract immediate forms take seven cycles
// (RULE12) 101xx sss logic ops on register; four
// (RULE13) Logic ops on memory operand; seven cycles
// (RULE14) 111xx110 logic ops on immediate; seven
// (RULE15) 000xx111 rotates accumulator; four cycles
// (RULE16) Register step four cycles, memory ten
// (RULE17) Complement, carry and decimal adjust: four
// (RULE18) Control ops four cycles, halt five
package opcode_decoder_pkg;

    // Opcode field positions
    localparam int GRP_MSB = 7;
    localparam int GRP_LSB = 6;
    localparam int DST_MSB = 5;
    localparam int DST_LSB = 3;
    localparam int SRC_MSB = 2;
    localparam int SRC_LSB = 0;
    localparam int PAIR_MSB = 5;
    localparam int PAIR_LSB = 4;
    localparam int DIR_BIT = 3;

    // Cycle counts per instruction class
    localparam logic [4:0] CYC_4 = 5'h04;
    localparam logic [4:0] CYC_5 = 5'h05;
    localparam logic [4:0] CYC_6 = 5'h06;
    localparam logic [4:0] CYC_7 = 5'h07;
    localparam logic [4:0] CYC_10 = 5'h0a;
    localparam logic [4:0] CYC_12 = 5'h0c;
    localparam logic [4:0] CYC_ONE = 5'h01;

    // Fixed opcodes of single-byte specials
    localparam logic [7:0] OPC_HALT = 8'h76;
    localparam logic [7:0] OPC_NOP = 8'h00;
    localparam logic [7:0] OPC_RD_MASK = 8'h20;
    localparam logic [7:0] OPC_WR_MASK = 8'h30;
    localparam logic [7:0] OPC_IRQ_ON = 8'hfb;
    localparam logic [7:0] OPC_IRQ_OFF = 8'hf3;

    // Field values with a special meaning
    localparam logic [2:0] FLD_MEM = 3'h6;
    localparam logic [2:0] FLD_STEP = 3'h3;
    localparam logic [2:0] FLD_INC8 = 3'h4;
    localparam logic [2:0] FLD_DEC8 = 3'h5;
    localparam logic [2:0] FLD_DADD = 3'h1;
    localparam logic [2:0] FLD_ACC = 3'h7;
    localparam logic [2:0] FLD_CRET = 3'h0;

    typedef enum logic [2:0] {
        reg_b, reg_c, reg_d, reg_e, reg_h, reg_l, reg_mem, reg_acc
    } reg_sel_e;

    typedef enum logic [1:0] {
        pair_bc, pair_de, pair_hl, pair_sp
    } pair_sel_e;

    typedef enum logic [1:0] {
        opnd_none, opnd_reg, opnd_mem, opnd_imm
    } operand_e;

    typedef enum logic [4:0] {
        op_unknown, inc_reg8, dec_reg8, inc_pair, dec_pair, pair_add_to_hl,
        op_add, op_add_carry, op_sub, sub_with_borrow,
        and_with_acc, xor_with_acc, or_with_acc, compare_with_acc,
        rotate_left, rotate_right, rotate_left_thru_carry, rotate_right_thru_carry,
        complement_acc, set_carry_flag, complement_carry_flag, decimal_adjust,
        irq_enable_op, irq_disable_op, no_operation, halt_op,
        read_irq_mask, set_irq_mask, cond_return
    } op_e;

    typedef struct packed {
        op_e op;
        operand_e operand;
        reg_sel_e dest;
        reg_sel_e src;
        pair_sel_e pair;
        logic [2:0] cond;
        logic cond_dep;
        logic [4:0] cycles;
    } decode_s;

    // Register field to selector, used for destination and source
    function automatic reg_sel_e reg_field(input logic [2:0] f);
        return reg_sel_e'(f);
    endfunction

    // Arithmetic and logic group selector from bits 5:3
    function automatic op_e alu_op(input logic [2:0] f);
        op_e r;
        unique case (f)
            3'h0: r = op_add;
            3'h1: r = op_add_carry;
            3'h2: r = op_sub;
            3'h3: r = sub_with_borrow;
            3'h4: r = and_with_acc;
            3'h5: r = xor_with_acc;
            3'h6: r = or_with_acc;
            3'h7: r = compare_with_acc;
        endcase
        return r;
    endfunction

endpackage

// *** src/cpu8_opcode_decoder.sv ***
// Opcode decoder with per-instruction cycle count and busy tracking
`timescale 1ns/1ps
`default_nettype none
module cpu8_opcode_decoder
    import opcode_decoder_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Fetched opcode
    input wire logic [7:0] opcode,
    input wire logic opcode_valid,
    input wire logic cond_met,
    // Decode result
    output decode_s decoded,
    output logic decoded_valid,
    output logic busy,
    output logic instr_done
);

    // Decode of the byte on the bus, loaded on accept
    decode_s next_dec;
    // Cycles still to run after the current one
    logic [4:0] remain;
    logic [2:0] grp_dst;
    logic [2:0] grp_src;
    logic accept;

    assign grp_dst = opcode[DST_MSB:DST_LSB];
    assign grp_src = opcode[SRC_MSB:SRC_LSB];
    assign accept = opcode_valid && !busy;

    // Combinational decode of the opcode byte
    always_comb
    begin
        // Defaults: unknown op, no operand, four cycles
        next_dec = '0;
        next_dec.op = op_unknown;
        next_dec.operand = opnd_none;
        // (RULE1) Register field decode
        next_dec.dest = reg_field(grp_dst);
        next_dec.src = reg_field(grp_src);
        // (RULE3) Pair field decode
        next_dec.pair = pair_sel_e'(opcode[PAIR_MSB:PAIR_LSB]);
        next_dec.cond = grp_dst;
        next_dec.cycles = CYC_4;
        unique case (opcode[GRP_MSB:GRP_LSB])
            2'b00:
            begin
                unique case (grp_src)
                    FLD_INC8, FLD_DEC8:
                    begin
                        // (RULE16) Register or memory step
                        if (grp_src == FLD_INC8)
                            next_dec.op = inc_reg8;
                        else
                            next_dec.op = dec_reg8;
                        // Memory form costs the extra bus cycles
                        if (grp_dst == FLD_MEM)
                        begin
                            next_dec.operand = opnd_mem;
                            next_dec.cycles = CYC_10;
                        end
                        else
                        begin
                            next_dec.operand = opnd_reg;
                            next_dec.cycles = CYC_4;
                        end
                    end
                    FLD_STEP:
                    begin
                        // (RULE4) Pair increment or decrement
                        next_dec.op = opcode[DIR_BIT] ? dec_pair : inc_pair;
                        next_dec.cycles = CYC_6;
                    end
                    FLD_DADD:
                    begin
                        // (RULE5) Pair added to HL
                        if (opcode[DIR_BIT])
                        begin
                            next_dec.op = pair_add_to_hl;
                            next_dec.cycles = CYC_10;
                        end
                    end
                    FLD_ACC:
                    begin
                        // (RULE15) Rotates and (RULE17) specials
                        unique case (grp_dst)
                            3'h0: next_dec.op = rotate_left;
                            3'h1: next_dec.op = rotate_right;
                            3'h2: next_dec.op = rotate_left_thru_carry;
                            3'h3: next_dec.op = rotate_right_thru_carry;
                            3'h4: next_dec.op = decimal_adjust;
                            3'h5: next_dec.op = complement_acc;
                            3'h6: next_dec.op = set_carry_flag;
                            3'h7: next_dec.op = complement_carry_flag;
                        endcase
                    end
                    FLD_CRET:
                    begin
                        // (RULE18) No-op and mask access
                        if (opcode == OPC_NOP)
                        begin
                            next_dec.op = no_operation;
                        end
                        else if (opcode == OPC_RD_MASK)
                        begin
                            next_dec.op = read_irq_mask;
                        end
                        else if (opcode == OPC_WR_MASK)
                        begin
                            next_dec.op = set_irq_mask;
                        end
                        // Other codes here stay unknown
                    end
                    default: next_dec.op = op_unknown;
                endcase
            end
            2'b01:
            begin
                // Register moves are outside this block
                // (RULE18) Halt takes five cycles
                if (opcode == OPC_HALT)
                begin
                    next_dec.op = halt_op;
                    next_dec.cycles = CYC_5;
                end
            end
            2'b10:
            begin
                // (RULE6) (RULE9) (RULE12) Register operand forms
                next_dec.op = alu_op(grp_dst);
                next_dec.operand = opnd_reg;
                if (grp_src == FLD_MEM)
                begin
                    // (RULE7) (RULE10) (RULE13) Memory operand forms
                    next_dec.operand = opnd_mem;
                    next_dec.cycles = CYC_7;
                end
            end
            2'b11:
            begin
                if (grp_src == FLD_MEM)
                begin
                    // (RULE8) (RULE11) (RULE14) Immediate forms
                    next_dec.op = alu_op(grp_dst);
                    next_dec.operand = opnd_imm;
                    next_dec.cycles = CYC_7;
                end
                else if (opcode == OPC_IRQ_ON)
                begin
                    // (RULE18) Interrupt enable, four cycles
                    next_dec.op = irq_enable_op;
                end
                else if (opcode == OPC_IRQ_OFF)
                begin
                    // (RULE18) Interrupt disable, four cycles
                    next_dec.op = irq_disable_op;
                end
                else if (grp_src == FLD_CRET)
                begin
                    // (RULE2) Short count when condition fails
                    next_dec.op = cond_return;
                    next_dec.cond_dep = 1'b1;
                    next_dec.cycles = cond_met ? CYC_12 : CYC_6;
                end
            end
        endcase
    end

    // Decode result register, loaded on accepted opcode
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            decoded <= '0;
            decoded_valid <= 1'b0;
        end
        else
        begin
            decoded_valid <= accept;
            if (accept)
                decoded <= next_dec;
        end
    end

    // Cycle counter tracks the running instruction
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            remain <= '0;
            busy <= 1'b0;
            instr_done <= 1'b0;
        end
        else
        begin
            instr_done <= 1'b0;
            if (accept)
            begin
                remain <= next_dec.cycles - CYC_ONE;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                // Count down; new opcodes wait meanwhile
                remain <= remain - CYC_ONE;
                // Last count frees the decoder next cycle
                if (remain == CYC_ONE)
                begin
                    busy <= 1'b0;
                    instr_done <= 1'b1; // Last cycle of instruction
                end
            end
        end
    end

endmodule
`default_nettype wire

// *** testbench/program_memory_model.sv ***
// Program memory model handing opcode bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module program_memory_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Fetch request from the bench
    input wire logic fetch,
    input wire logic [7:0] next_byte,
    input wire logic busy,
    // Opcode bus
    output logic [7:0] opcode,
    output logic opcode_valid
);
    // Hold byte until taken, then scramble the stale bus
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            opcode_valid <= 1'h0;
            opcode <= 8'h00;
        end
        else if (opcode_valid && !busy)
        begin
            opcode_valid <= 1'h0;
            opcode <= ~opcode;
        end
        else if (fetch && !opcode_valid)
        begin
            opcode_valid <= 1'h1;
            opcode <= next_byte;
        end
    end
endmodule
`default_nettype wire

// *** testbench/cpu8_opcode_decoder_monitor.sv ***
// Checker of decode results and instruction timing
`timescale 1ns/1ps
`default_nettype none
module cpu8_opcode_decoder_monitor
    import opcode_decoder_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Fetched opcode
    input wire logic [7:0] opcode,
    input wire logic opcode_valid,
    input wire logic cond_met,
    // Decode result
    input wire decode_s decoded,
    input wire logic decoded_valid,
    input wire logic busy,
    input wire logic instr_done
);
    // Opcode taken at this edge, and its fields
    wire logic acc = opcode_valid && !busy;
    wire logic [1:0] grp = opcode[7:6];
    wire logic [2:0] lo = opcode[2:0];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_pair_step: assert property (acc && grp == 2'h0 && lo == 3'h3 |=>
        decoded.cycles == 5'h06 && decoded.op == ($past(opcode[3]) ? dec_pair : inc_pair))
        else $error("pair step decode wrong");
    a_pair_add: assert property (acc && grp == 2'h0 && opcode[3:0] == 4'h9 |=>
        decoded.op == pair_add_to_hl && decoded.cycles == 5'h0a)
        else $error("pair add decode wrong");
    a_alu_reg: assert property (acc && grp == 2'h2 && lo != 3'h6 |=>
        decoded.operand == opnd_reg && decoded.cycles == 5'h04)
        else $error("register alu decode wrong");
    a_alu_mem: assert property (acc && grp == 2'h2 && lo == 3'h6 |=>
        decoded.operand == opnd_mem && decoded.cycles == 5'h07)
        else $error("memory alu decode wrong");
    a_alu_imm: assert property (acc && grp == 2'h3 && lo == 3'h6 |=>
        decoded.operand == opnd_imm && decoded.cycles == 5'h07)
        else $error("immediate alu decode wrong");
    a_cond_len: assert property (acc && grp == 2'h3 && lo == 3'h0 |=>
        decoded.cycles == ($past(cond_met) ? 5'h0c : 5'h06))
        else $error("conditional count wrong");
    a_src_field: assert property (acc |=> decoded.src == $past(opcode[2:0]))
        else $error("source field wrong");
    a_four_span: assert property (decoded_valid && decoded.cycles == 5'h04 |->
        ##1 !instr_done[*2] ##1 instr_done)
        else $error("four cycle span wrong");
endmodule
bind cpu8_opcode_decoder cpu8_opcode_decoder_monitor cpu8_opcode_decoder_monitor_i (
    .sys_clk, .sys_rst, .opcode, .opcode_valid, .cond_met,
    .decoded, .decoded_valid, .busy, .instr_done);
`default_nettype wire

// *** testbench/tb_cpu8_opcode_decoder.sv ***
// Testbench for the opcode decoder with a program memory model
`timescale 1ns/1ps
`default_nettype none
module tb_cpu8_opcode_decoder;
    import opcode_decoder_pkg::*;
    typedef struct {logic [7:0] o; logic c; op_e e; logic [4:0] n;} row_s;
    logic sys_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic fetch = 1'h0;
    logic cond_met = 1'h0;
    logic [7:0] next_byte = 8'h00;
    wire logic [7:0] opcode;
    wire logic opcode_valid, decoded_valid, busy, instr_done;
    decode_s decoded;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    op_e alu[8] = '{op_add, op_add_carry, op_sub, sub_with_borrow,
        and_with_acc, xor_with_acc, or_with_acc, compare_with_acc};
    row_s rows[$] = '{'{8'h03, 1'h0, inc_pair, 5'h06}, '{8'h3b, 1'h0, dec_pair, 5'h06},
        '{8'h39, 1'h0, pair_add_to_hl, 5'h0a}, '{8'h07, 1'h0, rotate_left, 5'h04},
        '{8'h0f, 1'h0, rotate_right, 5'h04}, '{8'h17, 1'h0, rotate_left_thru_carry, 5'h04},
        '{8'h1f, 1'h0, rotate_right_thru_carry, 5'h04}, '{8'h0c, 1'h0, inc_reg8, 5'h04},
        '{8'h15, 1'h0, dec_reg8, 5'h04}, '{8'h34, 1'h0, inc_reg8, 5'h0a},
        '{8'h35, 1'h0, dec_reg8, 5'h0a}, '{8'h2f, 1'h0, complement_acc, 5'h04},
        '{8'h37, 1'h0, set_carry_flag, 5'h04}, '{8'h3f, 1'h0, complement_carry_flag, 5'h04},
        '{8'h27, 1'h0, decimal_adjust, 5'h04}, '{8'hfb, 1'h0, irq_enable_op, 5'h04},
        '{8'hf3, 1'h0, irq_disable_op, 5'h04}, '{8'h00, 1'h0, no_operation, 5'h04},
        '{8'h20, 1'h0, read_irq_mask, 5'h04}, '{8'h30, 1'h0, set_irq_mask, 5'h04},
        '{8'h76, 1'h0, halt_op, 5'h05}, '{8'hc8, 1'h0, cond_return, 5'h06},
        '{8'hd0, 1'h1, cond_return, 5'h0c}};
    cpu8_opcode_decoder cpu8_opcode_decoder_i (.sys_clk, .sys_rst, .opcode, .opcode_valid,
        .cond_met, .decoded, .decoded_valid, .busy, .instr_done);
    program_memory_model program_memory_model_i (.sys_clk, .sys_rst, .fetch, .next_byte,
        .busy, .opcode, .opcode_valid);
    // Clock and hang limit
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic issue(input logic [7:0] o, input logic c);
        @(posedge sys_clk);
        fetch <= 1'h1;
        next_byte <= o;
        cond_met <= c;
        @(posedge sys_clk);
        fetch <= 1'h0;
    endtask
    // Count edges until the given output shows high
    task automatic wait_hi(input logic sel, output int k);
        k = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        while ((sel ? instr_done : decoded_valid) !== 1'h1 && k < 40);
    endtask
    initial
    begin
        int k;
        row_s r;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'h0;
        #1;
        chk(decoded.op, op_unknown);
        chk(busy, 1'h0);
        for (int f = 0; f < 8; f++)
        begin
            rows.push_back('{{2'h2, 3'(f), f == 6 ? 3'h7 : 3'(f)}, 1'h0, alu[f], 5'h04});
            rows.push_back('{{2'h2, 3'(f), 3'h6}, 1'h0, alu[f], 5'h07});
            rows.push_back('{{2'h3, 3'(f), 3'h6}, 1'h0, alu[f], 5'h07});
        end
        foreach (rows[i])
        begin
            r = rows[i];
            issue(r.o, r.c);
            wait_hi(1'h0, k);
            chk(decoded.op, r.e);
            chk(decoded.src, r.o[2:0]);
            chk(decoded.dest, r.o[5:3]);
            chk(decoded.pair, r.o[5:4]);
            chk(decoded.cycles, r.n);
            chk(decoded.cond_dep, r.e == cond_return);
            chk(decoded.cond, r.o[5:3]);
            if (r.o[7] && (!r.o[6] || r.o[2:0] == 3'h6))
                chk(decoded.operand, r.o[6] ? opnd_imm : r.o[2:0] == 3'h6 ? opnd_mem : opnd_reg);
            wait_hi(1'h1, k);
            chk(8'(k), 8'(r.n) - 8'h01);
        end
        // Second fetch while busy must wait out all ten cycles
        issue(8'h34, 1'h0);
        wait_hi(1'h0, k);
        issue(8'h80, 1'h0);
        wait_hi(1'h0, k);
        chk(8'(k), 8'h08);
        chk(decoded.op, op_add);
        wait_hi(1'h1, k);
        // Reset in mid instruction
        issue(8'h09, 1'h0);
        wait_hi(1'h0, k);
        @(posedge sys_clk);
        sys_rst <= 1'h1;
        @(posedge sys_clk);
        sys_rst <= 1'h0;
        #1;
        chk(busy, 1'h0);
        chk(decoded.op, op_unknown);
        issue(8'hfe, 1'h0);
        wait_hi(1'h0, k);
        chk(decoded.op, compare_with_acc);
        give_verdict();
    end
endmodule
`default_nettype wire
